// *** pfem_pkg.sv ***
// Package for the frequency event monitor: event codes, control layout, widths, reset values.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pfem_pkg;
  // Event select codes
  localparam logic [7:0] EV_BAND0 = 8'h0b;
  localparam logic [7:0] EV_BAND1 = 8'h0c;
  localparam logic [7:0] EV_BAND2 = 8'h0d;
  localparam logic [7:0] EV_BAND3 = 8'h0e;
  localparam logic [7:0] EV_CURRENT = 8'h07;
  localparam logic [7:0] EV_THERMAL = 8'h04;
  localparam logic [7:0] EV_OS = 8'h06;
  localparam logic [7:0] EV_POWER = 8'h05;
  localparam logic [7:0] EV_IO_MIN = 8'h61;
  localparam logic [7:0] EV_PERF_MIN = 8'h02;
  localparam logic [7:0] EV_TRANS = 8'h60;
  localparam logic [7:0] EV_PHASE_SHED = 8'h2f;
  localparam logic [7:0] EV_CORE9_DEMO = 8'h41;
  // Counter control word layout
  localparam int CTL_EV_LSB = 0;
  localparam int CTL_EDGE_BIT = 18;
  localparam int CTL_EN_BIT = 22;
  localparam int CTL_INV_BIT = 23;
  localparam int CTL_XSEL_BIT = 21;
  // Register map of this block
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_FILTER = 4'h4;
  localparam logic [3:0] ADDR_CNT0 = 4'h8;
  localparam logic [3:0] ADDR_FREEZE = 4'hc;
  localparam logic [3:0] ADDR_STATUS = 4'hd;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
  localparam int NUM_CNT = 4;
  localparam int CNT_W = 32;
  localparam int RATIO_W = 8;
endpackage
`default_nettype wire

// *** pfem_monitor.sv ***
// Frequency residency, limit reason, transition and demotion event counters.
// Assumes event inputs come from logic on the same clock; registers reached over a plain strobe port.
//
// Contract
// - Band events 0x0b..0x0e count cycles with ratio at or above their filter byte.
// - Edge detect on a band event counts entries into the at-or-above state.
// - Inversion on a band event counts cycles below threshold.
// - All four counters may select band events at once.
// - Control and threshold settings take effect only at the next frequency transition.
// - Band counting skips transition cycles; band state updates only on a transition.
// - Code 0x07 counts cycles where current is the strongest upper limit.
// - A fast-path current limit clears the other upper-limit reason flags.
// - Code 0x04 counts thermal strongest upper limit, from selection output.
// - Code 0x06 counts cycles where the OS request is the upper limit.
// - Code 0x05 counts cycles where power budget is the upper limit.
// - Code 0x61 counts cycles where IO bandwidth holds the frequency up.
// - Code 0x02 with extra select bit counts remote performance lower limit.
// - Code 0x60 counts every frequency change cycle, no thread filter.
// - Code 0x2f counts cycles with memory controller phase shedding active.
// - Code 0x41 counts core 9 demotions, qualified by filter low byte.
// - Each event adds at most one per cycle, on counters 0 to 3.
//
// Implementation choices: the address map and the strobed register port.
`default_nettype none
module pfem_monitor
  import pfem_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // Frequency control inputs
  input wire logic [RATIO_W-1:0] I_FREQ_RATIO,
  input wire logic I_FREQ_TRANS,
  input wire logic I_LIM_CURRENT_FAST,
  input wire logic I_LIM_THERMAL,
  input wire logic I_LIM_OS,
  input wire logic I_LIM_POWER,
  input wire logic I_LIM_IO_MIN,
  input wire logic I_LIM_PERF_MIN,
  input wire logic I_PHASE_SHED,
  input wire logic I_CORE9_DEMOTE,
  input wire logic [7:0] I_CORE9_DEMOTE_TAG,
  // Counter values
  output logic [NUM_CNT*W-1:0] O_COUNT
);

  logic [31:0] ctl_r [NUM_CNT];
  logic [31:0] ctl_act_r [NUM_CNT];
  logic [31:0] filt_r;
  logic [31:0] filt_act_r;
  logic freeze_r;
  logic [W-1:0] cnt_r [NUM_CNT];
  logic [NUM_CNT-1:0] band_r;
  logic [NUM_CNT-1:0] band_prev_r;
  logic lim_cur_r, lim_th_r, lim_os_r, lim_pw_r;
  logic [NUM_CNT-1:0] inc;

  // Threshold byte for a band
  function automatic logic [7:0] band_thr(input logic [31:0] f, input int b);
    band_thr = f[8*b +: 8];
  endfunction

  // Software-side control shadow; pending values wait for a transition
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        ctl_r[i] <= CTL_RESET;
      end
      filt_r <= FILTER_RESET;
      freeze_r <= 1'b0;
    end else if (I_WR) begin
      if (I_ADDR[3:2] == ADDR_CTL0[3:2]) begin
        ctl_r[I_ADDR[1:0]] <= I_WDATA;
      end else if (I_ADDR == ADDR_FILTER) begin
        filt_r <= I_WDATA;
      end else if (I_ADDR == ADDR_FREEZE) begin
        freeze_r <= I_WDATA[0];
      end
    end
  end

  // Active settings; a long constant frequency keeps stale settings, a known limitation
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        ctl_act_r[i] <= CTL_RESET;
      end
      filt_act_r <= FILTER_RESET;
    end else if (I_FREQ_TRANS) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        ctl_act_r[i] <= ctl_r[i];
      end
      filt_act_r <= filt_r;
    end
  end

  // Band residency state, refreshed only while a transition is under way
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      band_r <= '0;
    end else if (I_FREQ_TRANS) begin
      for (int b = 0; b < NUM_CNT; b++) begin
        band_r[b] <= (I_FREQ_RATIO >= band_thr(filt_r, b));
      end
    end
  end

  // Previous band state for edge detect
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      band_prev_r <= '0;
    end else if (!I_FREQ_TRANS) begin
      band_prev_r <= band_r;
    end
  end

  // Upper-limit reason flags; the fast current path clears the slower reasons
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lim_cur_r <= 1'b0;
      lim_th_r <= 1'b0;
      lim_os_r <= 1'b0;
      lim_pw_r <= 1'b0;
    end else begin
      lim_cur_r <= I_LIM_CURRENT_FAST;
      lim_th_r <= I_LIM_CURRENT_FAST ? 1'b0 : I_LIM_THERMAL;
      lim_os_r <= I_LIM_CURRENT_FAST ? 1'b0 : I_LIM_OS;
      lim_pw_r <= I_LIM_CURRENT_FAST ? 1'b0 : I_LIM_POWER;
    end
  end

  // Per-counter event selection; each counter decodes independently
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      logic [7:0] ev;
      logic edg, inv, xs, en, e;
      int b;
      ev = ctl_act_r[i][CTL_EV_LSB +: 8];
      edg = ctl_act_r[i][CTL_EDGE_BIT];
      inv = ctl_act_r[i][CTL_INV_BIT];
      xs = ctl_act_r[i][CTL_XSEL_BIT];
      en = ctl_act_r[i][CTL_EN_BIT];
      e = 1'b0;
      b = 0;
      if (ev >= EV_BAND0 && ev <= EV_BAND3) begin
        b = int'(ev - EV_BAND0);
        if (I_FREQ_TRANS) begin
          e = 1'b0;
        end else if (edg) begin
          e = band_r[b] & ~band_prev_r[b];
        end else if (inv) begin
          e = ~band_r[b];
        end else begin
          e = band_r[b];
        end
      end else if (ev == EV_CURRENT) begin
        e = lim_cur_r;
      end else if (ev == EV_THERMAL) begin
        e = lim_th_r;
      end else if (ev == EV_OS) begin
        e = lim_os_r;
      end else if (ev == EV_POWER) begin
        e = lim_pw_r;
      end else if (ev == EV_IO_MIN) begin
        e = I_LIM_IO_MIN;
      end else if (ev == EV_PERF_MIN) begin
        e = xs & I_LIM_PERF_MIN;
      end else if (ev == EV_TRANS) begin
        e = I_FREQ_TRANS;
      end else if (ev == EV_PHASE_SHED) begin
        e = I_PHASE_SHED;
      end else if (ev == EV_CORE9_DEMO) begin
        e = I_CORE9_DEMOTE && (I_CORE9_DEMOTE_TAG == filt_act_r[7:0]);
      end
      inc[i] = e & en & ~freeze_r;
    end
  end

  // Counters: a register write wins over counting in the same cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (I_WR && I_ADDR == ADDR_CNT0 + 4'(i)) begin
          cnt_r[i] <= I_WDATA[W-1:0];
        end else if (inc[i]) begin
          cnt_r[i] <= cnt_r[i] + W'(1);
        end
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= '0;
    end else if (I_RD) begin
      if (I_ADDR[3:2] == ADDR_CTL0[3:2]) begin
        O_RDATA <= ctl_r[I_ADDR[1:0]];
      end else if (I_ADDR == ADDR_FILTER) begin
        O_RDATA <= filt_r;
      end else if (I_ADDR[3:2] == ADDR_CNT0[3:2]) begin
        O_RDATA <= 32'(cnt_r[I_ADDR[1:0]]);
      end else if (I_ADDR == ADDR_FREEZE) begin
        O_RDATA <= {31'h0, freeze_r};
      end else if (I_ADDR == ADDR_STATUS) begin
        O_RDATA <= {24'h0, lim_pw_r, lim_os_r, lim_th_r, lim_cur_r, band_r};
      end else begin
        O_RDATA <= '0;
      end
    end else begin
      O_RDATA <= '0;
    end
  end

  // Counter outputs straight from flip-flops
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      O_COUNT[i*W +: W] = cnt_r[i];
    end
  end

  // Settings written between transitions stay inactive
  AST_SETTINGS_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !$past(I_FREQ_TRANS) |-> filt_act_r == $past(filt_act_r))
    else $error("active filter changed without a transition");

  // No band residency count during transition cycles
  AST_BAND_NO_TRANS: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_FREQ_TRANS && ctl_act_r[0][7:0] == EV_BAND0 && !ctl_act_r[0][CTL_EDGE_BIT] |-> !inc[0])
    else $error("band counted during transition");

  // Band state follows the threshold compare at a transition
  AST_BAND_CMP: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_FREQ_TRANS |=> band_r[3] == ($past(I_FREQ_RATIO) >= $past(filt_r[31:24])))
    else $error("band 3 state wrong");

  // Current limit clears the other reason flags next cycle
  AST_FAST_CLEAR: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    I_LIM_CURRENT_FAST |=> lim_cur_r && !lim_th_r && !lim_os_r && !lim_pw_r)
    else $error("slow limits not cleared");

  // Frozen counters stay put unless written
  AST_FREEZE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    freeze_r && !I_WR |=> cnt_r[2] == $past(cnt_r[2]))
    else $error("counter moved while frozen");

  // At most one added per cycle
  AST_STEP_ONE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !I_WR |=> (cnt_r[2] - $past(cnt_r[2])) <= W'(1))
    else $error("counter stepped by more than one");

  // Transition event counts each transition cycle
  AST_TRANS_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[0][7:0] == EV_TRANS && ctl_act_r[0][CTL_EN_BIT] && !freeze_r && I_FREQ_TRANS |-> inc[0])
    else $error("transition cycle missed");

  // Perf lower limit needs the extra select bit
  AST_PERF_XSEL: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[1][7:0] == EV_PERF_MIN && !ctl_act_r[1][CTL_XSEL_BIT] |-> !inc[1])
    else $error("perf limit counted without extra select");

  // Control words written between transitions stay pending
  AST_CTL_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !$past(I_FREQ_TRANS) |-> ctl_act_r[2] == $past(ctl_act_r[2]))
    else $error("active control changed without a transition");

  // Band state only moves while a transition is under way
  AST_BAND_STATE_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !I_FREQ_TRANS |=> band_r == $past(band_r))
    else $error("band state moved outside a transition");

  // Edge mode counts the first settled cycle after entering the band
  AST_BAND_EDGE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[1][7:0] == EV_BAND3 && ctl_act_r[1][CTL_EDGE_BIT] && ctl_act_r[1][CTL_EN_BIT] && !freeze_r
      && !I_FREQ_TRANS && band_r[3] && !band_prev_r[3] |-> inc[1])
    else $error("band entry not counted");

  // Inverted band counts the cycles below threshold
  AST_BAND_INV: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[0][7:0] == EV_BAND3 && ctl_act_r[0][CTL_INV_BIT] && !ctl_act_r[0][CTL_EDGE_BIT]
      && ctl_act_r[0][CTL_EN_BIT] && !freeze_r && !I_FREQ_TRANS |-> inc[0] == !band_r[3])
    else $error("inverted band count wrong");

  // A band on counter 2 counts beside the bands on the other counters
  AST_BAND_MULTI: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[2][7:0] == EV_BAND2 && ctl_act_r[2][CTL_EN_BIT] && !ctl_act_r[2][CTL_EDGE_BIT]
      && !ctl_act_r[2][CTL_INV_BIT] && !freeze_r && !I_FREQ_TRANS |-> inc[2] == band_r[2])
    else $error("band 2 residency count wrong");

  // Current limit counts one cycle after the fast path reports it
  AST_CURRENT_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[0][7:0] == EV_CURRENT && ctl_act_r[0][CTL_EN_BIT] && !freeze_r
      |-> inc[0] == $past(I_LIM_CURRENT_FAST))
    else $error("current limit count wrong");

  // Thermal limit counts only when current does not override it
  AST_THERMAL_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[1][7:0] == EV_THERMAL && ctl_act_r[1][CTL_EN_BIT] && !freeze_r
      |-> inc[1] == ($past(I_LIM_THERMAL) && !$past(I_LIM_CURRENT_FAST)))
    else $error("thermal limit count wrong");

  // OS request limit counts only when current does not override it
  AST_OS_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[2][7:0] == EV_OS && ctl_act_r[2][CTL_EN_BIT] && !freeze_r
      |-> inc[2] == ($past(I_LIM_OS) && !$past(I_LIM_CURRENT_FAST)))
    else $error("os limit count wrong");

  // Power limit counts only when current does not override it
  AST_POWER_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[3][7:0] == EV_POWER && ctl_act_r[3][CTL_EN_BIT] && !freeze_r
      |-> inc[3] == ($past(I_LIM_POWER) && !$past(I_LIM_CURRENT_FAST)))
    else $error("power limit count wrong");

  // IO lower limit counts in the cycle it is reported
  AST_IO_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[0][7:0] == EV_IO_MIN && ctl_act_r[0][CTL_EN_BIT] && !freeze_r |-> inc[0] == I_LIM_IO_MIN)
    else $error("io limit count wrong");

  // Remote perf limit counts when the extra select bit is set
  AST_PERF_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[1][7:0] == EV_PERF_MIN && ctl_act_r[1][CTL_XSEL_BIT] && ctl_act_r[1][CTL_EN_BIT] && !freeze_r
      |-> inc[1] == I_LIM_PERF_MIN)
    else $error("perf limit count wrong");

  // Phase shedding counts in the cycle it is reported
  AST_SHED_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[2][7:0] == EV_PHASE_SHED && ctl_act_r[2][CTL_EN_BIT] && !freeze_r |-> inc[2] == I_PHASE_SHED)
    else $error("phase shedding count wrong");

  // Only demotions whose tag matches the active low filter byte count
  AST_DEMOTE_CNT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ctl_act_r[2][7:0] == EV_CORE9_DEMO && ctl_act_r[2][CTL_EN_BIT] && !freeze_r
      |-> inc[2] == (I_CORE9_DEMOTE && I_CORE9_DEMOTE_TAG == filt_act_r[7:0]))
    else $error("core 9 demotion count wrong");

  // A counter without its local enable stays put unless written
  AST_COUNT_EN: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !ctl_act_r[3][CTL_EN_BIT] && !I_WR |=> cnt_r[3] == $past(cnt_r[3]))
    else $error("disabled counter moved");

endmodule
`default_nettype wire

// *** pfem_freq_ctl_model.sv ***
// Model of the frequency control logic that feeds the event monitor.
// Assumes the bench requests transitions and limit reasons just after rising edges.
`default_nettype none
module pfem_freq_ctl #(
  parameter int TL = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Requests from the bench
  input wire logic i_go,
  input wire logic [7:0] i_target,
  input wire logic [6:0] i_lims,
  // Signals to the monitor
  output logic [7:0] o_ratio,
  output logic o_trans,
  output logic [6:0] o_lims
);
  logic [3:0] left_r;
  // New ratio shows at once; the transition flag stays up TL cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ratio <= 8'h00;
      left_r <= 4'h0;
    end else if (i_go) begin
      o_ratio <= i_target;
      left_r <= 4'(TL);
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  // Limit reasons pass straight through, as the selection output would
  assign o_trans = (left_r != 4'h0);
  assign o_lims = i_lims;
endmodule
`default_nettype wire

// *** test_power_unit_freq_event_monitor.sv ***
// Self-checking bench for the frequency event monitor.
// Assumes pfem_pkg, pfem_monitor and the frequency control model are compiled first.
`default_nettype none
module test_power_unit_freq_event_monitor import pfem_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] EN = 32'h0040_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic go = 1'b0;
  logic [7:0] tgt = 8'h00;
  logic [6:0] lims = 7'h00;
  logic [7:0] ratio;
  logic trans;
  logic [6:0] lim_o;
  logic dem = 1'b0;
  logic [7:0] tag = 8'h00;
  logic [4*CNT_W-1:0] count;
  int fails = 0;
  int checks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  // Far side and device
  pfem_freq_ctl i_ctl (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_target(tgt), .i_lims(lims),
    .o_ratio(ratio), .o_trans(trans), .o_lims(lim_o));
  pfem_monitor i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_FREQ_RATIO(ratio), .I_FREQ_TRANS(trans), .I_LIM_CURRENT_FAST(lim_o[0]),
    .I_LIM_THERMAL(lim_o[1]), .I_LIM_OS(lim_o[2]), .I_LIM_POWER(lim_o[3]), .I_LIM_IO_MIN(lim_o[4]),
    .I_LIM_PERF_MIN(lim_o[5]), .I_PHASE_SHED(lim_o[6]), .I_CORE9_DEMOTE(dem), .I_CORE9_DEMOTE_TAG(tag),
    .O_COUNT(count));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] cnt(input int k);
    return count[k*32 +: 32];
  endfunction
  // Counts are sampled well after the edge so the registered update has landed
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #10;
    chk(rdata, exp);
  endtask
  // One frequency transition; two cycles of transition flag inside seven edges
  task automatic shift(input logic [7:0] t);
    @(posedge clk);
    go <= 1'b1;
    tgt <= t;
    @(posedge clk);
    go <= 1'b0;
    run(5);
  endtask
  task automatic t_bands();
    logic [31:0] s[4];
    wreg(ADDR_FILTER, 32'h4030_2010);
    for (int k = 0; k < 4; k++)
      wreg(ADDR_CTL0 + 4'(k), EN | 32'(EV_BAND0 + 8'(k)));
    run(10);
    chk(cnt(0), 32'h0);
    rreg(ADDR_CTL0 + 4'h3, EN | 32'h0e);
    shift(8'h30);
    for (int k = 0; k < 4; k++)
      s[k] = cnt(k);
    run(20);
    for (int k = 0; k < 4; k++)
      chk(cnt(k) - s[k], (k < 3) ? 32'd20 : 32'd0);
    s[0] = cnt(0);
    shift(8'h31);
    run(13);
    chk(cnt(0) - s[0], 32'd18);
  endtask
  task automatic t_inv_edge();
    logic [31:0] s;
    wreg(ADDR_CTL0, EN | 32'h0080_000e);
    wreg(ADDR_CTL0 + 4'h1, EN | 32'h0004_000e);
    shift(8'h31);
    s = cnt(0);
    run(20);
    chk(cnt(0) - s, 32'd20);
    s = cnt(1);
    shift(8'h50);
    shift(8'h20);
    shift(8'h50);
    run(5);
    chk(cnt(1) - s, 32'd2);
  endtask
  // Each reason held five cycles; the last rows are current over thermal, transition cycles,
  // and the remote perf limit without its extra select bit, which must not count
  task automatic t_limits();
    logic [7:0] code[10] = '{EV_CURRENT, EV_THERMAL, EV_OS, EV_POWER, EV_IO_MIN, EV_PERF_MIN,
      EV_PHASE_SHED, EV_THERMAL, EV_TRANS, EV_PERF_MIN};
    logic [6:0] bits[10] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h03, 7'h00, 7'h20};
    logic [31:0] s;
    int k;
    for (int i = 0; i < 10; i++) begin
      k = i % 4;
      wreg(ADDR_CTL0 + 4'(k), EN | 32'(code[i]) | ((code[i] == EV_PERF_MIN && i != 9) ? 32'h0020_0000 : 32'h0));
      shift(8'h20);
      s = cnt(k);
      if (bits[i] == 7'h00) begin
        shift(8'h20);
      end else begin
        @(posedge clk);
        lims <= bits[i];
        repeat (5) @(posedge clk);
        lims <= 7'h00;
      end
      run(6);
      chk(cnt(k) - s, (i == 7 || i == 9) ? 32'd0 : (bits[i] == 7'h00) ? 32'd2 : 32'd5);
    end
  endtask
  // Three matching and two foreign demotions
  task automatic demote5();
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      dem <= 1'b1;
      tag <= (j < 3) ? 8'h09 : 8'h05;
      @(posedge clk);
      dem <= 1'b0;
    end
    run(3);
  endtask
  task automatic t_demote_regs();
    logic [31:0] s;
    wreg(ADDR_FILTER, 32'h4030_2009);
    wreg(ADDR_CTL0 + 4'h2, EN | 32'h41);
    shift(8'h20);
    s = cnt(2);
    demote5();
    chk(cnt(2) - s, 32'd3);
    wreg(ADDR_FREEZE, 32'h1);
    s = cnt(2);
    demote5();
    chk(cnt(2) - s, 32'd0);
    rreg(4'h7, 32'h0);
    wreg(ADDR_CNT0 + 4'h1, 32'h0000_0100);
    rreg(ADDR_CNT0 + 4'h1, 32'h0000_0100);
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_bands();
    t_inv_edge();
    t_limits();
    t_demote_regs();
    print_verdict();
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
